// ==== inc/pcao_map.svh ====
// Constants for the port C alternate-function override block.
// Assumes a single 40 MHz core clock and a synchronous active-high reset.
//
// Overview of operation
// - Reset-role signal overrides pin 6 pull-up, forcing it on.
// - Reset-role signal forces pin 6 to input; its output value is never overridden.
// - Pin 6 input enable overridden by reset role or mask with group enable.
// - Two-wire enable overrides pins 5,4 pull-up: latch bit set and no global disable.
// - Two-wire enable: pin 5 direction follows clock drive, pin 4 data drive.
// - Two-wire enable forces pins 5,4 output value low, giving open drain.
// - Pins 5,4 input enable overridden by mask-and-group or analog digital disable.
// - Pins 3 to 0 never override pull-up, direction or output value.
// - Pins 3 to 0 input enable overridden by mask-and-group or analog disable.
// - Port C pin n drives pin-change source 8 plus n.
// - Two-wire inputs come from pins 5,4 analog path through spike filters.
// - Neighbouring port pin n drives pin-change source 16 plus n.
// - Global pull-up disable turns off every ordinary port pull-up.
// - Pin 6 serves reset circuitry in reset role, normal I/O otherwise.
// - In reset role, pin 6 direction, latch and input read back as zero.
// - Two-wire enable makes pin 5 the clock line and pin 4 the data line.
`ifndef PCAO_MAP_SVH
`define PCAO_MAP_SVH

`define PCAO_NPINS       7
`define PCAO_NPINS_D     8
`define PCAO_NSRC        24
`define PCAO_SRC_BASE_C  8
`define PCAO_SRC_BASE_D  16
`define PCAO_BIT_RST     6
`define PCAO_BIT_SCL     5
`define PCAO_BIT_SDA     4
`define PCAO_CLK_NS      25
`define PCAO_SPIKE_NS    50
`define PCAO_SPIKE_CYC   ((`PCAO_SPIKE_NS + `PCAO_CLK_NS - 1) / `PCAO_CLK_NS)
`define PCAO_CNT_W       2

`endif

// ==== inc/pcao_pkg.sv ====
// Types shared by the port C override logic.
// Assumes pcao_map.svh is on the include path.
`include "pcao_map.svh"

package pcao_pkg;

    typedef logic [`PCAO_NPINS-1:0] pcao_vec_t;

    // Two fields per controlled attribute (enable and value), one bit per pin.
    typedef struct packed {
        pcao_vec_t pu_oe;
        pcao_vec_t pu_ov;
        pcao_vec_t dd_oe;
        pcao_vec_t dd_ov;
        pcao_vec_t pv_oe;
        pcao_vec_t pv_ov;
        pcao_vec_t die_oe;
        pcao_vec_t die_ov;
    } pcao_ovr_t;

    // Normal port register view for the seven pins.
    typedef struct packed {
        pcao_vec_t dir;
        pcao_vec_t latch;
    } pcao_port_t;

endpackage

// ==== verilog/pcao_spike_filter.sv ====
// Spike filter between a pin's analog path and the two-wire logic.
// Assumes the input is already synchronised to core_clk_in.
`timescale 1ns/1ps

module pcao_spike_filter
    import pcao_pkg::*;
(
    input  wire logic core_clk_in, // Core clock.
    input  wire logic reset_in,    // Synchronous reset, active high.
    input  wire logic raw_in,      // Synchronised line level.
    output logic      clean_out    // Filtered line level.
);

    logic [`PCAO_CNT_W-1:0] stable_cnt_ff;
    logic                   clean_ff;

    // A level is accepted only after it differs from the output for the
    // whole spike window; shorter pulses restart the count.  The count also
    // restarts on the accepting edge, so the next edge always needs a full window.
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            stable_cnt_ff <= '0;
        end else if ((raw_in == clean_ff) ||
                     (stable_cnt_ff == `PCAO_CNT_W'(`PCAO_SPIKE_CYC - 1))) begin
            stable_cnt_ff <= '0;
        end else begin
            stable_cnt_ff <= stable_cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            clean_ff <= 1'b1;
        end else if ((raw_in != clean_ff) &&
                     (stable_cnt_ff == `PCAO_CNT_W'(`PCAO_SPIKE_CYC - 1))) begin
            clean_ff <= raw_in;
        end
    end

    assign clean_out = clean_ff;

endmodule

// ==== verilog/pcao_port_c_override.sv ====
// Alternate-function override logic for the seven-pin port C.
// Pad inputs arrive from the package pins and are synchronised here; all
// other inputs come from core logic on the same clock.
`timescale 1ns/1ps

module pcao_port_c_override
    import pcao_pkg::*;
(
    input  wire logic                     core_clk_in,       // Core clock, 40 MHz.
    input  wire logic                     reset_in,          // Synchronous reset, high.
    input  wire logic [`PCAO_NPINS-1:0]   dir_reg_in,        // Direction register bits.
    input  wire logic [`PCAO_NPINS-1:0]   latch_reg_in,      // Port latch bits.
    input  wire logic                     global_pullup_disable_in, // Kill pull-ups, except pin 6 in reset role.
    input  wire logic                     reset_pin_fuse_in, // High: pin 6 in reset role.
    input  wire logic                     two_wire_enable_in, // Two-wire interface on.
    input  wire logic                     twi_scl_drive_in,  // Clock-drive from interface.
    input  wire logic                     twi_sda_drive_in,  // Data-drive from interface.
    input  wire logic                     pin_change_group1_enable_in, // Group 1 enable.
    input  wire logic [`PCAO_NPINS-1:0]   pin_change_mask_in, // Per-pin change masks.
    input  wire logic [5:0]               analog_digital_disable_in, // Channels 5..0.
    input  wire logic [`PCAO_NPINS-1:0]   pad_in,            // Pad levels, asynchronous.
    input  wire logic [`PCAO_NPINS_D-1:0] port_d_digital_in, // Neighbour port inputs.
    output logic      [`PCAO_NPINS-1:0]   pad_out_out,       // Pad output value.
    output logic      [`PCAO_NPINS-1:0]   pad_oe_out,        // Pad drive enable.
    output logic      [`PCAO_NPINS-1:0]   pad_pullup_out,    // Pad pull-up enable.
    output logic      [`PCAO_NPINS-1:0]   input_enable_out,  // Digital input enable.
    output logic      [`PCAO_NPINS-1:0]   dir_read_out,      // Direction read-back.
    output logic      [`PCAO_NPINS-1:0]   latch_read_out,    // Latch read-back.
    output logic      [`PCAO_NPINS-1:0]   pin_read_out,      // Pin input read-back.
    output logic      [`PCAO_NSRC-1:0]    pin_change_src_out, // Pin-change sources.
    output logic                          reset_sense_out,   // Pin 6 to reset circuit.
    output logic      [3:0]               analog_chan_out,   // Converter channels 3..0.
    output logic                          twi_scl_in_out,    // Filtered clock line.
    output logic                          twi_sda_in_out     // Filtered data line.
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Per-pin select between override and normal value.
    function automatic pcao_vec_t pick(input pcao_vec_t oe,
                                       input pcao_vec_t ov,
                                       input pcao_vec_t normal);
        pick = (oe & ov) | (~oe & normal);
    endfunction

    // ------------------------------------------------------------------
    // Pad synchronisers
    // ------------------------------------------------------------------

    pcao_vec_t pad_meta_ff;
    pcao_vec_t pad_sync_ff;

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            pad_meta_ff <= '0;
            pad_sync_ff <= '0;
        end else begin
            pad_meta_ff <= pad_in;
            pad_sync_ff <= pad_meta_ff;
        end
    end

    // ------------------------------------------------------------------
    // Override signals
    // ------------------------------------------------------------------

    pcao_ovr_t  ovr;
    pcao_port_t port;
    pcao_vec_t  pc_term;
    logic       rst_role;
    logic       tw_on;

    assign port     = '{dir: dir_reg_in, latch: latch_reg_in};
    assign rst_role = reset_pin_fuse_in;
    assign tw_on    = two_wire_enable_in;
    assign pc_term  = pin_change_mask_in & {`PCAO_NPINS{pin_change_group1_enable_in}};

    always_comb begin
        ovr = '0;
        // Pin 6 in reset role: input with pull-up on, output value untouched.
        ovr.pu_oe[`PCAO_BIT_RST]  = rst_role;
        ovr.pu_ov[`PCAO_BIT_RST]  = 1'b1;
        ovr.dd_oe[`PCAO_BIT_RST]  = rst_role;
        ovr.dd_ov[`PCAO_BIT_RST]  = 1'b0;
        ovr.die_oe[`PCAO_BIT_RST] = rst_role | pc_term[`PCAO_BIT_RST];
        ovr.die_ov[`PCAO_BIT_RST] = rst_role;
        // Two-wire pins: open drain, direction from the interface.
        ovr.pu_oe[`PCAO_BIT_SCL]  = tw_on;
        ovr.pu_oe[`PCAO_BIT_SDA]  = tw_on;
        ovr.pu_ov[`PCAO_BIT_SCL]  = port.latch[`PCAO_BIT_SCL] & ~global_pullup_disable_in;
        ovr.pu_ov[`PCAO_BIT_SDA]  = port.latch[`PCAO_BIT_SDA] & ~global_pullup_disable_in;
        ovr.dd_oe[`PCAO_BIT_SCL]  = tw_on;
        ovr.dd_oe[`PCAO_BIT_SDA]  = tw_on;
        ovr.dd_ov[`PCAO_BIT_SCL]  = twi_scl_drive_in;
        ovr.dd_ov[`PCAO_BIT_SDA]  = twi_sda_drive_in;
        ovr.pv_oe[`PCAO_BIT_SCL]  = tw_on;
        ovr.pv_oe[`PCAO_BIT_SDA]  = tw_on;
        ovr.pv_ov[`PCAO_BIT_SCL]  = 1'b0;
        ovr.pv_ov[`PCAO_BIT_SDA]  = 1'b0;
        // Input enable for the analog-capable pins 5..0.
        ovr.die_oe[5:4] = pc_term[5:4] | analog_digital_disable_in[5:4];
        ovr.die_ov[5:4] = pc_term[5:4];
        ovr.die_oe[3:0] = pc_term[3:0] | analog_digital_disable_in[3:0];
        ovr.die_ov[3:0] = pc_term[3:0];
    end

    // ------------------------------------------------------------------
    // Resolved pad controls
    // ------------------------------------------------------------------

    pcao_vec_t nxt_pullup;
    pcao_vec_t nxt_oe;
    pcao_vec_t nxt_out;
    pcao_vec_t nxt_ie;
    pcao_vec_t norm_pullup;

    // Ordinary pull-up needs input direction, latch one and no global kill.
    assign norm_pullup = ~port.dir & port.latch &
                         {`PCAO_NPINS{~global_pullup_disable_in}};
    assign nxt_pullup  = pick(ovr.pu_oe, ovr.pu_ov, norm_pullup);
    assign nxt_oe      = pick(ovr.dd_oe, ovr.dd_ov, port.dir);
    assign nxt_out     = pick(ovr.pv_oe, ovr.pv_ov, port.latch);
    assign nxt_ie      = pick(ovr.die_oe, ovr.die_ov, {`PCAO_NPINS{1'b1}});

    pcao_vec_t pad_pullup_ff;
    pcao_vec_t pad_oe_ff;
    pcao_vec_t pad_out_ff;
    pcao_vec_t input_enable_ff;

    // Reset leaves every pad an input without pull-up, which is the safe state.
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            pad_pullup_ff   <= '0;
            pad_oe_ff       <= '0;
            pad_out_ff      <= '0;
            input_enable_ff <= '0;
        end else begin
            pad_pullup_ff   <= nxt_pullup;
            pad_oe_ff       <= nxt_oe;
            pad_out_ff      <= nxt_out;
            input_enable_ff <= nxt_ie;
        end
    end

    // ------------------------------------------------------------------
    // Digital input path and read-back
    // ------------------------------------------------------------------

    pcao_vec_t digital_in;
    pcao_vec_t rd_mask;

    // A disabled input buffer reads low rather than following the pad.
    assign digital_in = pad_sync_ff & nxt_ie;
    assign rd_mask    = {~rst_role, {(`PCAO_NPINS-1){1'b1}}};

    pcao_vec_t dir_read_ff;
    pcao_vec_t latch_read_ff;
    pcao_vec_t pin_read_ff;

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            dir_read_ff   <= '0;
            latch_read_ff <= '0;
            pin_read_ff   <= '0;
        end else begin
            dir_read_ff   <= port.dir & rd_mask;
            latch_read_ff <= port.latch & rd_mask;
            pin_read_ff   <= digital_in & rd_mask;
        end
    end

    // ------------------------------------------------------------------
    // Pin-change sources
    // ------------------------------------------------------------------

    logic [`PCAO_NSRC-1:0] nxt_src;
    logic [`PCAO_NSRC-1:0] src_ff;

    always_comb begin
        nxt_src = '0;
        nxt_src[`PCAO_SRC_BASE_C +: `PCAO_NPINS]   = digital_in;
        nxt_src[`PCAO_SRC_BASE_D +: `PCAO_NPINS_D] = port_d_digital_in;
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            src_ff <= '0;
        end else begin
            src_ff <= nxt_src;
        end
    end

    // ------------------------------------------------------------------
    // Analog paths
    // ------------------------------------------------------------------

    logic       reset_sense_ff;
    logic [3:0] analog_chan_ff;

    // The reset path bypasses the input enable so a disabled buffer can
    // never hide an external reset.
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            reset_sense_ff <= 1'b1;
            analog_chan_ff <= '0;
        end else begin
            reset_sense_ff <= pad_sync_ff[`PCAO_BIT_RST] | ~rst_role;
            analog_chan_ff <= pad_sync_ff[3:0];
        end
    end

    // ------------------------------------------------------------------
    // Two-wire input filters
    // ------------------------------------------------------------------

    logic scl_clean;
    logic sda_clean;

    // Filters read the analog path, so they work even while the digital
    // input buffer is switched off by an analog disable bit.
    pcao_spike_filter u_scl_filter (
        .core_clk_in (core_clk_in),
        .reset_in    (reset_in),
        .raw_in      (pad_sync_ff[`PCAO_BIT_SCL]),
        .clean_out   (scl_clean)
    );

    pcao_spike_filter u_sda_filter (
        .core_clk_in (core_clk_in),
        .reset_in    (reset_in),
        .raw_in      (pad_sync_ff[`PCAO_BIT_SDA]),
        .clean_out   (sda_clean)
    );

    logic twi_scl_ff;
    logic twi_sda_ff;

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            twi_scl_ff <= 1'b1;
            twi_sda_ff <= 1'b1;
        end else begin
            twi_scl_ff <= scl_clean;
            twi_sda_ff <= sda_clean;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------

    assign pad_out_out        = pad_out_ff;
    assign pad_oe_out         = pad_oe_ff;
    assign pad_pullup_out     = pad_pullup_ff;
    assign input_enable_out   = input_enable_ff;
    assign dir_read_out       = dir_read_ff;
    assign latch_read_out     = latch_read_ff;
    assign pin_read_out       = pin_read_ff;
    assign pin_change_src_out = src_ff;
    assign reset_sense_out    = reset_sense_ff;
    assign analog_chan_out    = analog_chan_ff;
    assign twi_scl_in_out     = twi_scl_ff;
    assign twi_sda_in_out     = twi_sda_ff;

endmodule

// ==== sim/pcao_port_c_override_monitor.sv ====
// Concurrent checks on the port C override block, bound to its top module.
// Assumes every control input is synchronous to core_clk_in.
`timescale 1ns/1ps
module pcao_port_c_override_monitor
    import pcao_pkg::*;
(
    input wire logic        core_clk_in,                 // Clock.
    input wire logic        reset_in,                    // Reset.
    input wire logic [6:0]  dir_reg_in,                  // Direction.
    input wire logic [6:0]  latch_reg_in,                // Latch.
    input wire logic        global_pullup_disable_in,    // Pull-up kill.
    input wire logic        reset_pin_fuse_in,           // Reset role.
    input wire logic        two_wire_enable_in,          // Two-wire on.
    input wire logic        twi_scl_drive_in,            // Clock drive.
    input wire logic        twi_sda_drive_in,            // Data drive.
    input wire logic        pin_change_group1_enable_in, // Group enable.
    input wire logic [6:0]  pin_change_mask_in,          // Masks.
    input wire logic [5:0]  analog_digital_disable_in,   // Disables.
    input wire logic [6:0]  pad_in,                      // Pads.
    input wire logic [6:0]  pad_out_out,                 // Pad value.
    input wire logic [6:0]  pad_oe_out,                  // Pad drive.
    input wire logic [6:0]  pad_pullup_out,              // Pull-up.
    input wire logic [6:0]  input_enable_out,            // Input enable.
    input wire logic [6:0]  dir_read_out,                // Dir read.
    input wire logic [6:0]  latch_read_out,              // Latch read.
    input wire logic [6:0]  pin_read_out,                // Pin read.
    input wire logic [23:0] pin_change_src_out,          // Sources.
    input wire logic        twi_scl_in_out               // Filtered clock.
);
    // ----
    // Checks
    // ----
    logic [6:0] mg;
    logic [6:0] ie_exp;
    logic [3:0] low_pu;
    logic [1:0] twi_pu;
    logic [1:0] drv;
    assign mg = pin_change_mask_in & {7{pin_change_group1_enable_in}};
    assign ie_exp = {reset_pin_fuse_in | ~mg[6], mg[5:0] | ~analog_digital_disable_in};
    assign low_pu = ~dir_reg_in[3:0] & latch_reg_in[3:0] & ~{4{global_pullup_disable_in}};
    assign twi_pu = latch_reg_in[5:4] & ~{2{global_pullup_disable_in}};
    assign drv = {twi_scl_drive_in, twi_sda_drive_in};

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (reset_in);

    // Six samples cover the synchroniser and the filter with a cycle to spare.
    sequence s_scl_pad_high;
        pad_in[5] [*6];
    endsequence

    a_rst_pullup_on: assert property (reset_pin_fuse_in |=> pad_pullup_out[6])
        else $error("pin 6 pull-up not forced on");
    a_rst_dir_input: assert property (reset_pin_fuse_in |=> !pad_oe_out[6])
        else $error("pin 6 not forced to input");
    a_rst_reads_zero: assert property (reset_pin_fuse_in |=>
        {dir_read_out[6], latch_read_out[6], pin_read_out[6]} == 3'h0)
        else $error("pin 6 read-back not zero");
    a_twi_dir_follow: assert property (two_wire_enable_in |=>
        pad_oe_out[5:4] == $past(drv))
        else $error("two-wire direction wrong");
    a_twi_drive_low: assert property (two_wire_enable_in |=> pad_out_out[5:4] == 2'h0)
        else $error("two-wire output value not low");
    a_twi_pullup_gate: assert property (two_wire_enable_in |=>
        pad_pullup_out[5:4] == $past(twi_pu))
        else $error("two-wire pull-up wrong");
    a_low_pins_plain: assert property (1'b1 |=> pad_oe_out[3:0] == $past(dir_reg_in[3:0])
        && pad_out_out[3:0] == $past(latch_reg_in[3:0]) && pad_pullup_out[3:0] == $past(low_pu))
        else $error("pins 3 to 0 overridden");
    a_pud_kills_all: assert property (global_pullup_disable_in && !reset_pin_fuse_in |=>
        pad_pullup_out == 7'h00)
        else $error("pull-up on while disabled");
    a_input_enable_mux: assert property (!reset_in |=> input_enable_out == $past(ie_exp))
        else $error("input enable wrong");
    a_src_spare_zero: assert property (pin_change_src_out[7:0] == 8'h00
        && !pin_change_src_out[15])
        else $error("unused source bit set");
    a_scl_filter_pass: assert property (s_scl_pad_high |=> twi_scl_in_out)
        else $error("filtered clock line not high");
endmodule

bind pcao_port_c_override pcao_port_c_override_monitor u_mon (
    .core_clk_in, .reset_in, .dir_reg_in, .latch_reg_in, .global_pullup_disable_in,
    .reset_pin_fuse_in, .two_wire_enable_in, .twi_scl_drive_in, .twi_sda_drive_in,
    .pin_change_group1_enable_in, .pin_change_mask_in, .analog_digital_disable_in, .pad_in,
    .pad_out_out, .pad_oe_out, .pad_pullup_out, .input_enable_out, .dir_read_out,
    .latch_read_out, .pin_read_out, .pin_change_src_out, .twi_scl_in_out
);

// ==== sim/pcao_pin_model.sv ====
// Behavioural pads and outside drivers for the seven port C pins.
// Assumes the testbench steers the outside drivers.
`timescale 1ns/1ps
module pcao_pin_model (
    input  wire logic       core_clk_in, // Clock for the float pattern.
    input  wire logic [6:0] pad_out_in,  // Port output value.
    input  wire logic [6:0] pad_oe_in,   // Port drive enable.
    input  wire logic [6:0] pullup_in,   // Port pull-up enable.
    input  wire logic [6:0] ext_oe_in,   // Outside drive enable.
    input  wire logic [6:0] ext_val_in,  // Outside drive value.
    output logic      [6:0] level_out    // Pin level.
);
    // ----
    // Pin level
    // ----
    logic [6:0] float_ff = 7'h55;
    // A floating pin toggles so that a stale level never passes for a driven one.
    always_ff @(posedge core_clk_in) begin
        float_ff <= ~float_ff;
    end
    always_comb begin
        level_out = pad_oe_in & pad_out_in | ~pad_oe_in & (ext_oe_in & ext_val_in
            | ~ext_oe_in & (pullup_in | float_ff));
    end
endmodule

// ==== sim/test_pcao_port_c_override.sv ====
// Self-checking testbench for the port C override block.
// Assumes the checker file is compiled alongside and binds itself.
`timescale 1ns/1ps
module test_pcao_port_c_override
    import pcao_pkg::*;
;
    // ----
    // Stimulus and checks
    // ----
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        global_pullup_disable, fuse, tw, scl_d, sda_d, grp, rsense, tscl, tsda;
    logic [6:0]  dir, lat, mask, ext_oe, ext_val, pad, p_out, p_oe, p_pu, ie;
    logic [6:0]  dir_rd, lat_rd, pin_rd;
    logic [5:0]  add;
    logic [7:0]  portd;
    logic [3:0]  achan;
    logic [23:0] src;
    int          miscompares = 0;
    int          n_compared = 0;

    always #12.5 clk = ~clk;

    pcao_pin_model pins_u (.core_clk_in(clk), .pad_out_in(p_out), .pad_oe_in(p_oe),
        .pullup_in(p_pu), .ext_oe_in(ext_oe), .ext_val_in(ext_val), .level_out(pad));
    pcao_port_c_override dut_u (.core_clk_in(clk), .reset_in(rst), .dir_reg_in(dir),
        .latch_reg_in(lat), .global_pullup_disable_in(global_pullup_disable), .reset_pin_fuse_in(fuse),
        .two_wire_enable_in(tw), .twi_scl_drive_in(scl_d), .twi_sda_drive_in(sda_d),
        .pin_change_group1_enable_in(grp), .pin_change_mask_in(mask),
        .analog_digital_disable_in(add), .pad_in(pad), .port_d_digital_in(portd),
        .pad_out_out(p_out), .pad_oe_out(p_oe), .pad_pullup_out(p_pu), .input_enable_out(ie),
        .dir_read_out(dir_rd), .latch_read_out(lat_rd), .pin_read_out(pin_rd),
        .pin_change_src_out(src), .reset_sense_out(rsense), .analog_chan_out(achan),
        .twi_scl_in_out(tscl), .twi_sda_in_out(tsda));

    function automatic logic [6:0] f_pu();
        logic [6:0] p;
        p = ~dir & lat & ~{7{global_pullup_disable}};
        if (tw) p[5:4] = lat[5:4] & ~{2{global_pullup_disable}};
        if (fuse) p[6] = 1'b1;
        return p;
    endfunction
    function automatic logic [6:0] f_oe();
        logic [6:0] o;
        o = dir;
        if (tw) o[5:4] = {scl_d, sda_d};
        if (fuse) o[6] = 1'b0;
        return o;
    endfunction
    function automatic logic [6:0] f_ie();
        logic [6:0] m;
        m = mask & {7{grp}};
        return {fuse | ~m[6], m[5:0] | ~add};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_ctl();
        chk(p_pu, f_pu());
        chk(p_oe, f_oe());
        chk(p_out, tw ? lat & 7'h4F : lat);
        chk(ie, f_ie());
        chk({dir_rd, lat_rd}, {dir, lat} & {2{~fuse, 6'h3F}});
    endtask

    // Floating pins are left out, since their level is meaningless.
    task automatic chk_pad();
        logic [6:0] k, lv, di;
        k = f_oe() | ext_oe | f_pu();
        lv = f_oe() & (tw ? lat & 7'h4F : lat) | ~f_oe() & (ext_oe & ext_val | ~ext_oe);
        di = lv & f_ie();
        chk(pin_rd & k, di & k & {~fuse, 6'h3F});
        chk(src & {9'h1FF, k, 8'hFF}, {portd, 1'b0, di & k, 8'h00});
        chk(achan & k[3:0], lv[3:0] & k[3:0]);
        chk({tscl, tsda} & k[5:4], lv[5:4] & k[5:4]);
        chk(rsense, fuse ? lv[6] : 1'b1);
    endtask

    task automatic rnd_step();
        logic [31:0] r;
        logic [31:0] s;
        r = $urandom;
        s = $urandom;
        @(posedge clk);
        {grp, tw, fuse, global_pullup_disable, ext_val, mask, lat, dir} <= r;
        {sda_d, scl_d, portd, add, ext_oe} <= s[22:0];
    endtask

    task automatic give_verdict();
        $display("compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        {global_pullup_disable, fuse, tw, scl_d, sda_d, grp, dir, lat, mask, ext_oe, ext_val, add, portd} = '0;
        void'($urandom(32'h8F1010C0));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        #1 chk({p_pu, p_oe, ie, tscl, rsense}, 23'h3);
        // Every mix of reset role, two-wire and pull-up kill, with pull-ups requested.
        for (int c = 0; c < 8; c++) begin
            @(posedge clk);
            {fuse, tw, global_pullup_disable} <= 3'(c);
            {scl_d, sda_d, grp} <= 3'(c);
            {dir, lat, mask, ext_oe, ext_val} <= {7'h00, 7'h7F, 7'h7F, 7'h7F, 7'h2A};
            add <= 6'h33;
            // All eight port D inputs held low, so pin-change sources 23 to 16 read zero.
            portd <= 8'h00;
            repeat (8) @(posedge clk);
            #1 chk_ctl();
            chk_pad();
        end
        for (int i = 0; i < 300; i++) begin
            rnd_step();
            @(posedge clk);
            #1 chk_ctl();
            if (i % 4 == 0) begin
                repeat (7) @(posedge clk);
                #1 chk_pad();
            end
        end
        // A one-cycle spike on the clock line must not reach the interface.
        @(posedge clk);
        {tw, scl_d, ext_oe, ext_val} <= {2'b10, 7'h7F, 7'h00};
        repeat (8) @(posedge clk);
        ext_val <= 7'h20;
        @(posedge clk);
        ext_val <= 7'h00;
        repeat (8) begin
            @(posedge clk);
            #1 chk(tscl, 1'b0);
        end
        give_verdict();
    end

    initial begin
        #200000;
        miscompares++;
        give_verdict();
    end
endmodule
